/* File: rtl/swh_write_handler.sv */
/*
 * sector write command handler: task file over APB, busy / data request /
 * interrupt sequencing per 512-byte sector, hand-off to a media engine.
 * assumes the media engine pulses med_done once per med_start and reads
 * the buffer through med_rd_addr before that pulse.
 */
// Contract
// - opcodes 30h and 31h start the plain write with implied erase.
// - transfer 1 to 256 sectors; a count of zero means 256.
// - start at the addressed sector and proceed sequentially.
// - on accept: busy, then data request with busy cleared, await data.
// - no interrupt before the first sector's data transfer.
// - a full sector buffer sets busy and clears data request.
// - buffer ready again: clear busy, set data request, raise interrupt.
// - after the last sector, stay busy until done, then clear and interrupt.
// - on error stop at that sector, leaving its address in the task file.
// - opcode 38h writes with the same handshake but no implied erase.
// - a no-erase write to an unerased sector becomes an ordinary write.
// - opcode CDh is the block-multiple write without implied erase.
// - opcode 3Ch verifies each sector right after writing it.
// - write errors limited to bad block, id, abort, mark; never uncorrectable.
// - unknown opcode posts only the aborted error with error status.
// - each sector is 512 bytes through the sector buffer.
// - block address is head, cylinder high, cylinder low, sector number.
// - CDh is aborted if block size unset or multiple writes disabled.
`timescale 1ns/100ps
module swh_write_handler
   import swh_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // host-visible flags
   output logic             busy_flag,
   output logic             data_request_flag,
   output logic             host_irq,
   // media engine
   output logic             med_start,
   output logic             med_lba_mode,
   output logic [27:0]      med_addr,
   output logic             med_erase,
   output logic             med_verify,
   input  wire logic [7:0]  med_rd_addr,
   output logic [15:0]      med_rd_data,
   input  wire logic        sector_erased,
   input  wire logic        med_done,
   input  wire logic [4:0]  med_err
);
   swh_state_t  state, next_state;
   logic [7:0]  sec_cnt, next_sec_cnt, sec_num, next_sec_num, drv_head, next_drv_head;
   logic [15:0] cyl, next_cyl;
   logic [7:0]  err_reg, next_err_reg, opcode, next_opcode, blk_left, next_blk_left;
   logic [8:0]  remain, next_remain, cfg, next_cfg;
   logic        st_err, next_st_err, st_wf, next_st_wf, next_host_irq;
   logic [3:0]  idx, adv_head;
   logic [15:0] adv_cyl;
   logic [7:0]  adv_sec, status, err_bits;
   logic        mapped, acc, wr, rd, cmd_wr, is_write_op, multi_ok, buf_full;

   // ------------------------------------------------------------------
   // bus decode; zero wait states, so every access phase completes
   // ------------------------------------------------------------------
   assign idx     = paddr[5:2];
   assign mapped  = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00) && (idx <= IDX_MULTI_CFG);
   assign acc     = psel && penable;
   assign wr      = acc && pwrite && mapped;
   assign rd      = acc && !pwrite && mapped;
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
   assign cmd_wr  = wr && (idx == IDX_CMD_STAT) && (state == S_IDLE);

   assign busy_flag         = (state == S_ACCEPT) || (state == S_PROGRAM) ||
                              (state == S_WAIT_MEDIA);
   assign data_request_flag = (state == S_WAIT_DATA);
   // ready and seek complete always hold; corrected data never applies to writes
   assign status = {busy_flag, 1'b1, st_wf, 1'b1, data_request_flag, 1'b0, 1'b0, st_err};

   assign is_write_op = (pwdata[7:0] == OP_WRITE_A) || (pwdata[7:0] == OP_WRITE_B) ||
                        (pwdata[7:0] == OP_WRITE_NOERS) ||
                        (pwdata[7:0] == OP_WRITE_VFY) ||
                        (pwdata[7:0] == OP_MULTI_NOERS);
   assign multi_ok    = cfg[CFG_EN] && (cfg[7:0] != 8'h00);

   // only the write-valid error bits survive; uncorrectable stays clear
   always_comb begin
      err_bits          = 8'h00;
      err_bits[ER_BBK]  = med_err[ME_BBK];
      err_bits[ER_ID_NOT_FOUND_ERROR] = med_err[ME_ID_NOT_FOUND_ERROR];
      err_bits[ER_COMMAND_ABORTED_ERROR] = med_err[ME_COMMAND_ABORTED_ERROR];
      err_bits[ER_ADDRESS_MARK_MISSING_ERROR] = med_err[ME_ADDRESS_MARK_MISSING_ERROR];
   end

   // ------------------------------------------------------------------
   // media hand-off
   // ------------------------------------------------------------------
   assign med_lba_mode = drv_head[DH_LBA];
   assign med_addr     = {drv_head[3:0], cyl, sec_num};
   assign med_start    = (state == S_PROGRAM);
   // no-erase opcodes skip the erase only where the sector is already erased
   assign med_erase    = !(((opcode == OP_WRITE_NOERS) || (opcode == OP_MULTI_NOERS)) &&
                           sector_erased);
   assign med_verify   = (opcode == OP_WRITE_VFY);

   swh_sector_buf u_buf (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr && (idx == IDX_DATA) && (state == S_WAIT_DATA)),
      .wr_data (pwdata[15:0]),
      .clr     ((state == S_WAIT_MEDIA) && med_done),
      .full    (buf_full),
      .rd_addr (med_rd_addr),
      .rd_data (med_rd_data)
   );

   swh_addr_step u_step (
      .lba_mode  (drv_head[DH_LBA]),
      .head      (drv_head[3:0]),
      .cyl       (cyl),
      .sec       (sec_num),
      .next_head (adv_head),
      .next_cyl  (adv_cyl),
      .next_sec  (adv_sec)
   );

   // ------------------------------------------------------------------
   // command sequencer and task file
   // ------------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_sec_cnt  = sec_cnt;
      next_sec_num  = sec_num;
      next_cyl      = cyl;
      next_drv_head = drv_head;
      next_err_reg  = err_reg;
      next_opcode   = opcode;
      next_blk_left = blk_left;
      next_remain   = remain;
      next_cfg      = cfg;
      next_st_err   = st_err;
      next_st_wf    = st_wf;
      next_host_irq = host_irq;
      // reading status acknowledges; any event below overrides this clear
      if (rd && (idx == IDX_CMD_STAT)) begin
         next_host_irq = 1'b0;
      end
      // task file writes are ignored while a command runs
      if (wr && (state == S_IDLE)) begin
         unique case (idx)
            IDX_SEC_CNT:   next_sec_cnt  = pwdata[7:0];
            IDX_SEC_NUM:   next_sec_num  = pwdata[7:0];
            IDX_CYL_LO:    next_cyl[7:0] = pwdata[7:0];
            IDX_CYL_HI:    next_cyl[15:8] = pwdata[7:0];
            IDX_DRV_HEAD:  next_drv_head = pwdata[7:0];
            IDX_MULTI_CFG: next_cfg      = pwdata[8:0];
            default:       next_cfg      = cfg;
         endcase
      end
      unique case (state)
         S_IDLE: begin
            if (cmd_wr) begin
               next_opcode   = pwdata[7:0];
               next_err_reg  = 8'h00;
               next_st_err   = 1'b0;
               next_st_wf    = 1'b0;
               next_host_irq = 1'b0;
               if (!is_write_op ||
                   ((pwdata[7:0] == OP_MULTI_NOERS) && !multi_ok)) begin
                  next_err_reg[ER_COMMAND_ABORTED_ERROR] = 1'b1;
                  next_st_err           = 1'b1;
                  next_host_irq         = 1'b1;
               end else begin
                  next_remain   = (sec_cnt == 8'h00) ? MAX_SECTORS : {1'b0, sec_cnt};
                  next_blk_left = cfg[7:0];
                  next_state    = S_ACCEPT;
               end
            end
         end
         S_ACCEPT: begin
            next_state = S_WAIT_DATA;
         end
         S_WAIT_DATA: begin
            if (buf_full) begin
               next_state = S_PROGRAM;
            end
         end
         S_PROGRAM: begin
            next_state = S_WAIT_MEDIA;
         end
         S_WAIT_MEDIA: begin
            if (med_done) begin
               if ((err_bits != 8'h00) || med_err[ME_WF]) begin
                  // address registers still name the failing sector
                  next_err_reg  = err_bits;
                  next_st_err   = 1'b1;
                  next_st_wf    = med_err[ME_WF];
                  next_host_irq = 1'b1;
                  next_state    = S_IDLE;
               end else begin
                  next_remain  = remain - 9'h001;
                  next_sec_cnt = sec_cnt - 8'h01;
                  next_sec_num = adv_sec;
                  next_cyl     = adv_cyl;
                  next_drv_head = {drv_head[7:4], adv_head};
                  if (remain == 9'h001) begin
                     next_host_irq = 1'b1;
                     next_state    = S_IDLE;
                  end else begin
                     next_state = S_WAIT_DATA;
                     if (opcode != OP_MULTI_NOERS) begin
                        next_host_irq = 1'b1;
                     end else if (blk_left == 8'h01) begin
                        next_host_irq = 1'b1;
                        next_blk_left = cfg[7:0];
                     end else begin
                        next_blk_left = blk_left - 8'h01;
                     end
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= S_IDLE;
         sec_cnt  <= SEC_CNT_RST;
         sec_num  <= SEC_NUM_RST;
         cyl      <= CYL_RST;
         drv_head <= DRV_HEAD_RST;
         err_reg  <= 8'h00;
         opcode   <= 8'h00;
         blk_left <= 8'h00;
         remain   <= 9'h000;
         cfg      <= CFG_RST;
         st_err   <= 1'b0;
         st_wf    <= 1'b0;
         host_irq <= 1'b0;
      end else begin
         state    <= next_state;
         sec_cnt  <= next_sec_cnt;
         sec_num  <= next_sec_num;
         cyl      <= next_cyl;
         drv_head <= next_drv_head;
         err_reg  <= next_err_reg;
         opcode   <= next_opcode;
         blk_left <= next_blk_left;
         remain   <= next_remain;
         cfg      <= next_cfg;
         st_err   <= next_st_err;
         st_wf    <= next_st_wf;
         host_irq <= next_host_irq;
      end
   end

   // ------------------------------------------------------------------
   // read data, captured in the setup phase
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         unique case (idx)
            IDX_ERROR:     prdata <= {24'h000000, err_reg};
            IDX_SEC_CNT:   prdata <= {24'h000000, sec_cnt};
            IDX_SEC_NUM:   prdata <= {24'h000000, sec_num};
            IDX_CYL_LO:    prdata <= {24'h000000, cyl[7:0]};
            IDX_CYL_HI:    prdata <= {24'h000000, cyl[15:8]};
            IDX_DRV_HEAD:  prdata <= {24'h000000, drv_head};
            IDX_CMD_STAT:  prdata <= {24'h000000, status};
            IDX_MULTI_CFG: prdata <= {23'h000000, cfg};
            default:       prdata <= 32'h00000000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   AST_ACCEPT_SEQ: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && is_write_op && (pwdata[7:0] != OP_MULTI_NOERS) |=>
         busy_flag && !data_request_flag ##1 data_request_flag && !busy_flag)
      else $error("accept sequence busy then data request broken");
   AST_NO_FIRST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (state == S_ACCEPT) |-> !host_irq ##1 !host_irq)
      else $error("interrupt raised before first sector");
   AST_FULL_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
      (state == S_WAIT_DATA) && buf_full |=>
         busy_flag && !data_request_flag && med_start ##1 busy_flag && !med_start)
      else $error("full buffer did not start sector processing");
   AST_ZERO_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && is_write_op && (sec_cnt == 8'h00) && (pwdata[7:0] != OP_MULTI_NOERS) |=>
         (remain == 9'h100))
      else $error("zero count not taken as 256");
   AST_NEXT_SECTOR: assert property (@(posedge pclk) disable iff (!presetn)
      (state == S_WAIT_MEDIA) && med_done && (med_err == 5'h00) && (remain != 9'h001) &&
         (opcode != OP_MULTI_NOERS) |=> data_request_flag && !busy_flag && host_irq)
      else $error("next sector not requested with interrupt");
   AST_LAST_DONE: assert property (@(posedge pclk) disable iff (!presetn)
      (state == S_WAIT_MEDIA) && med_done && (med_err == 5'h00) && (remain == 9'h001) |=>
         !busy_flag && !data_request_flag && host_irq && (sec_cnt == 8'h00))
      else $error("last sector did not complete cleanly");
   AST_ERR_STOP: assert property (@(posedge pclk) disable iff (!presetn)
      (state == S_WAIT_MEDIA) && med_done && (med_err[3:0] != 4'h0) |=>
         st_err && host_irq && !busy_flag && $stable(sec_num) && $stable(cyl) &&
         (err_reg != 8'h00))
      else $error("error did not stop at failing sector");
   AST_INVALID_COMMAND_ABORTED_ERROR: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && !is_write_op |=> (err_reg == 8'h04) && st_err && host_irq && !busy_flag)
      else $error("invalid opcode not aborted");
   AST_MULTI_REJECT: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && (pwdata[7:0] == OP_MULTI_NOERS) && !multi_ok |=>
         err_reg[ER_COMMAND_ABORTED_ERROR] && (state == S_IDLE))
      else $error("unconfigured block write not rejected");
   AST_NO_UNC: assert property (@(posedge pclk) disable iff (!presetn)
      !err_reg[ER_UNC] && !status[ST_CORRECTED_DATA_FLAG])
      else $error("uncorrectable or corrected flag posted on write");

endmodule : swh_write_handler

/* File: rtl/swh_pkg.sv */
/*
 * shared constants and types of the sector write command handler: register
 * indices, opcodes, status and error bit positions, reset values, geometry.
 * assumes a 100 MHz APB clock and a 16-bit data register path into the buffer.
 */
package swh_pkg;

   // ------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [3:0] IDX_DATA      = 4'h0;
   localparam logic [3:0] IDX_ERROR     = 4'h1;
   localparam logic [3:0] IDX_SEC_CNT   = 4'h2;
   localparam logic [3:0] IDX_SEC_NUM   = 4'h3;
   localparam logic [3:0] IDX_CYL_LO    = 4'h4;
   localparam logic [3:0] IDX_CYL_HI    = 4'h5;
   localparam logic [3:0] IDX_DRV_HEAD  = 4'h6;
   localparam logic [3:0] IDX_CMD_STAT  = 4'h7;
   localparam logic [3:0] IDX_MULTI_CFG = 4'h8;

   // ------------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_A     = 8'h30;
   localparam logic [7:0] OP_WRITE_B     = 8'h31;
   localparam logic [7:0] OP_WRITE_NOERS = 8'h38;
   localparam logic [7:0] OP_WRITE_VFY   = 8'h3c;
   localparam logic [7:0] OP_MULTI_NOERS = 8'hcd;

   // ------------------------------------------------------------------
   // status and error bit positions
   // ------------------------------------------------------------------
   localparam int ST_BUSY  = 7;
   localparam int ST_READY = 6;
   localparam int ST_WF    = 5;
   localparam int ST_DSC   = 4;
   localparam int ST_DRQ   = 3;
   localparam int ST_CORRECTED_DATA_FLAG  = 2;
   localparam int ST_ERR   = 0;
   localparam int ER_BBK   = 7;
   localparam int ER_UNC   = 6;
   localparam int ER_ID_NOT_FOUND_ERROR  = 4;
   localparam int ER_COMMAND_ABORTED_ERROR  = 2;
   localparam int ER_ADDRESS_MARK_MISSING_ERROR  = 0;
   localparam int DH_LBA   = 6;
   localparam int CFG_EN   = 8;
   // media error input positions
   localparam int ME_BBK   = 0;
   localparam int ME_ID_NOT_FOUND_ERROR  = 1;
   localparam int ME_COMMAND_ABORTED_ERROR  = 2;
   localparam int ME_ADDRESS_MARK_MISSING_ERROR  = 3;
   localparam int ME_WF    = 4;

   // ------------------------------------------------------------------
   // reset values, sizes, geometry
   // ------------------------------------------------------------------
   localparam logic [7:0]  SEC_CNT_RST    = 8'h01;
   localparam logic [7:0]  SEC_NUM_RST    = 8'h01;
   localparam logic [7:0]  DRV_HEAD_RST   = 8'ha0;
   localparam logic [15:0] CYL_RST        = 16'h0000;
   localparam logic [8:0]  CFG_RST        = 9'h000;
   localparam int          SECTOR_BYTES   = 512;
   localparam int          SECTOR_WORDS   = SECTOR_BYTES / 2;
   localparam logic [8:0]  MAX_SECTORS    = 9'h100;
   localparam logic [7:0]  CHS_LAST_SEC   = 8'h20;
   localparam logic [3:0]  CHS_LAST_HEAD  = 4'hf;
   localparam logic [7:0]  CHS_FIRST_SEC  = 8'h01;

   typedef enum logic [2:0] {
      S_IDLE, S_ACCEPT, S_WAIT_DATA, S_PROGRAM, S_WAIT_MEDIA
   } swh_state_t;

endpackage : swh_pkg

/* File: rtl/swh_sector_buf.sv */
/*
 * one-sector buffer: host words fill it in order, the media engine reads it
 * by word address. assumes the writer stops at full and clears after use.
 */
`timescale 1ns/100ps
module swh_sector_buf
   import swh_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // fill side
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   input  wire logic        clr,
   output logic             full,
   // drain side
   input  wire logic [7:0]  rd_addr,
   output logic [15:0]      rd_data
);
   logic [15:0] mem [SECTOR_WORDS];
   logic [8:0]  wr_ptr;
   logic [8:0]  next_wr_ptr;

   // ------------------------------------------------------------------
   // fill pointer
   // ------------------------------------------------------------------
   always_comb begin
      next_wr_ptr = wr_ptr;
      if (clr) begin
         next_wr_ptr = 9'h000;
      end else if (wr_en && !full) begin
         next_wr_ptr = wr_ptr + 9'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= 9'h000;
      end else begin
         wr_ptr <= next_wr_ptr;
      end
   end

   assign full = (wr_ptr == 9'(SECTOR_WORDS));

   // ------------------------------------------------------------------
   // storage, no reset so it maps onto ram
   // ------------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (wr_en && !full && !clr) begin
         mem[wr_ptr[7:0]] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule : swh_sector_buf

/* File: rtl/swh_addr_step.sv */
/*
 * next sector address after a good sector, in block or cylinder-head-sector
 * form. assumes the fixed geometry held in the package.
 */
`timescale 1ns/100ps
module swh_addr_step
   import swh_pkg::*;
(
   // current address
   input  wire logic        lba_mode,
   input  wire logic [3:0]  head,
   input  wire logic [15:0] cyl,
   input  wire logic [7:0]  sec,
   // advanced address
   output logic [3:0]       next_head,
   output logic [15:0]      next_cyl,
   output logic [7:0]       next_sec
);
   logic [27:0] lba_inc;

   always_comb begin
      lba_inc   = {head, cyl, sec} + 28'h0000001;
      next_head = head;
      next_cyl  = cyl;
      next_sec  = sec;
      if (lba_mode) begin
         {next_head, next_cyl, next_sec} = lba_inc;
      end else if (sec != CHS_LAST_SEC) begin
         next_sec = sec + 8'h01;
      end else begin
         next_sec = CHS_FIRST_SEC;
         if (head != CHS_LAST_HEAD) begin
            next_head = head + 4'h1;
         end else begin
            next_head = 4'h0;
            next_cyl  = cyl + 16'h0001;
         end
      end
   end

endmodule : swh_addr_step

/* File: dv/swh_media_model.sv */
/* media engine model: answers each med_start with one med_done pulse.
   assumes the bench sets err_in and erased_in before the sector starts. */
`timescale 1ns/100ps
module swh_media_model
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // handler side
   input  wire logic       med_start,
   output logic            med_done,
   output logic [4:0]      med_err,
   output logic            sector_erased,
   output logic [7:0]      med_rd_addr,
   // scenario knobs
   input  wire logic [4:0] err_in,
   input  wire logic       erased_in
);
   logic [2:0] cnt;
   // outside its sample points the erased answer is inverted and the error answer toggles, so nothing leans on stale values
   assign sector_erased = med_start ? erased_in : ~erased_in;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
         med_done <= 1'b0;
         med_err <= 5'h1f;
         med_rd_addr <= 8'h00;
      end else begin
         med_done <= (cnt == 3'h1);
         med_err <= (cnt == 3'h1) ? err_in : ~med_err;
         med_rd_addr <= med_rd_addr + 8'h01;
         cnt <= med_start ? 3'h4 : ((cnt != 3'h0) ? cnt - 3'h1 : 3'h0);
      end
   end
endmodule : swh_media_model

/* File: dv/tb_top.sv */
/* bench of the write handler: host over apb, media model on the far side.
   assumes zero-wait apb answers and a short media delay. */
`timescale 1ns/100ps
module tb_top;
   import swh_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, erased = 0, se;
   logic        ers, vfy;
   logic [7:0]  paddr = 0, med_rd_addr;
   logic [31:0] pwdata = 0, q, prdata;
   logic [4:0]  err_in = 0, med_err;
   logic [28:0] ma;
   logic [27:0] med_addr;
   logic [15:0] med_rd_data;
   logic [31:0] rdw;
   logic [7:0]  ra;
   logic        med_lba_mode;
   logic pready, pslverr, busy_flag, data_request_flag, host_irq, med_start;
   logic med_erase, med_verify, sector_erased, med_done;
   int          err_count = 0, n_checks = 0;
   logic [7:0]  ops [4] = '{OP_WRITE_B, OP_WRITE_NOERS, OP_WRITE_NOERS, OP_WRITE_VFY};
   swh_write_handler uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .busy_flag, .data_request_flag, .host_irq, .med_start,
      .med_lba_mode, .med_addr, .med_erase, .med_verify, .med_rd_addr,
      .med_rd_data, .sector_erased, .med_done, .med_err);
   swh_media_model media (.pclk, .presetn, .med_start, .med_done, .med_err,
      .sector_erased, .med_rd_addr, .err_in, .erased_in(erased));
   always #5 pclk = ~pclk;
   // one buffer word is read back behind the model's walking address
   always @(posedge pclk) begin
      ra <= med_rd_addr;
      if (med_start) begin
         ers <= med_erase;
         vfy <= med_verify;
         ma  <= {med_lba_mode, med_addr};
         rdw <= {med_rd_data, 8'h00, ra};
      end
   end
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task apb(logic w, logic [3:0] i, logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, i, 2'b00}; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task rc(string nm, logic [3:0] i, logic [31:0] e);
      apb(0, i, 0);
      chk(nm, q, e);
   endtask : rc
   task wr(logic [7:0] op, int n, int ea, logic [4:0] e, logic [7:0] sn = 8'h01);
      apb(1, IDX_SEC_CNT, n);
      apb(1, IDX_SEC_NUM, {24'h000000, sn});
      apb(1, IDX_CMD_STAT, op);
      for (int s = 0; s < n; s++) begin
         // host waits for data request to set before moving data
         for (int k = 0; k < 50 && data_request_flag !== 1'b1; k++) @(negedge pclk);
         chk("busy", busy_flag, 0);
         chk("irq", host_irq, s != 0);
         err_in <= (s == ea) ? e : 5'h00;
         for (int k = 0; k < SECTOR_WORDS; k++) apb(1, IDX_DATA, k);
         // busy follows one edge after the last word fills the buffer
         repeat (2) @(negedge pclk);
         chk("busy_drq", {busy_flag, data_request_flag}, 2'b10);
         if (s == ea) break;
      end
      for (int k = 0; k < 50 && busy_flag !== 1'b0; k++) @(negedge pclk);
      chk("irq_end", host_irq, 1);
      chk("buf_word", rdw[31:16], rdw[15:0]);
   endtask : wr
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   initial begin
      #300_000;
      err_count++;
      end_of_test;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      rc("status", IDX_CMD_STAT, 32'h50);
      rc("drv_head", IDX_DRV_HEAD, 32'ha0);
      apb(0, 4'hc, 0);
      chk("pslverr", se, 1);
      wr(OP_WRITE_A, 2, 9, 0);
      rc("sec_num", IDX_SEC_NUM, 32'h03);
      $display("test plain write done");
      for (int i = 0; i < 4; i++) begin
         erased <= (i != 2);
         wr(ops[i], 1, 9, 0);
         chk("erase", ers, !(ops[i] == OP_WRITE_NOERS && i != 2));
         chk("verify", vfy, ops[i] == OP_WRITE_VFY);
      end
      $display("test opcodes done");
      wr(OP_WRITE_A, 2, 1, 5'h01);
      rc("error", IDX_ERROR, 32'h80);
      rc("status", IDX_CMD_STAT, 32'h51);
      rc("sec_num", IDX_SEC_NUM, 32'h02);
      rc("sec_cnt", IDX_SEC_CNT, 32'h01);
      $display("test media error done");
      apb(1, IDX_CMD_STAT, 32'hec);
      rc("error", IDX_ERROR, 32'h04);
      rc("status", IDX_CMD_STAT, 32'h51);
      apb(1, IDX_CMD_STAT, OP_MULTI_NOERS);
      rc("error", IDX_ERROR, 32'h04);
      apb(1, IDX_MULTI_CFG, 32'h101);
      wr(OP_MULTI_NOERS, 1, 9, 0);
      chk("erase", ers, 0);
      $display("test aborts done");
      apb(1, IDX_DRV_HEAD, 32'he0);
      apb(1, IDX_CYL_LO, 32'hff);
      wr(OP_WRITE_A, 1, 9, 0, 8'hff);
      chk("med_addr", ma, 32'h1000ffff);
      rc("cyl_hi", IDX_CYL_HI, 32'h01);
      rc("sec_num", IDX_SEC_NUM, 32'h00);
      $display("test block addressing done");
      wr(OP_WRITE_A, 256, 0, 0);
      rc("sec_cnt", IDX_SEC_CNT, 32'hff);
      rc("status", IDX_CMD_STAT, 32'h58);
      // reset in mid-command must drop every flag
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      rc("status", IDX_CMD_STAT, 32'h50);
      rc("sec_cnt", IDX_SEC_CNT, 32'h01);
      $display("test zero count and reset done");
      end_of_test;
   end
endmodule : tb_top
